// ==== threshold_value_comparator_tb_top.sv ====
// self-checking bench for the threshold value comparator
// assumes tvc_pkg, tvc_comparator and the scan sequencer model tvc_scan_model
`timescale 1ns/1ps
`default_nettype none

module threshold_value_comparator_tb_top
  import tvc_pkg::*;
();
  logic ref_clk;
  logic srst;
  logic run_mode;
  logic scan_req;
  logic scan_start;
  logic scan_done;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_INST-1:0] compare_result_flag;
  logic [NUM_INST-1:0] range_overflow_flag;
  logic scan_busy;
  logic irq;
  logic [NUM_INST-1:0] exp_res;
  logic [DATA_W-1:0] rd_q;
  int n_mismatch;
  int compares;

  tvc_comparator i_tvc_comparator (.ref_clk(ref_clk), .srst(srst), .run_mode(run_mode),
    .scan_start(scan_start), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_result_flag(compare_result_flag),
    .range_overflow_flag(range_overflow_flag), .scan_busy(scan_busy), .irq(irq));

  tvc_scan_model i_tvc_scan_model (.ref_clk(ref_clk), .srst(srst), .scan_req(scan_req),
    .scan_done(scan_done), .scan_busy(scan_busy), .scan_start(scan_start));

  // ---------------------------------------
  // bus and compare helpers
  // ---------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [ADDR_W-1:0] adr(input logic [4:0] i, input logic [3:0] f);
    return {1'b0, i, f};
  endfunction : adr

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_q = reg_rdata;
  endtask : rd

  task automatic run_scan();
    int busy_n;
    busy_n = 0;
    @(posedge ref_clk);
    scan_req <= 1'b1;
    @(posedge ref_clk);
    scan_req <= 1'b0;
    for (int k = 0; k < 100 && !scan_done; k++) begin
      @(negedge ref_clk);
      if (scan_busy === 1'b1) busy_n++;
    end
    check("scan_busy_cycles", 32'(busy_n), 32'h0000_0020);
  endtask : run_scan

  // new first operand, one scan, then the whole result vector
  task automatic step(input logic [4:0] i, input logic [31:0] op, input logic exp);
    wr(adr(i, FLD_FIRST_OPND), op);
    run_scan();
    exp_res[i] = exp;
    check("result_vec", compare_result_flag, exp_res);
  endtask : step

  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic t_reset();
    rd(adr(5'h1F, FLD_CTRL));
    check("ctrl_reset", rd_q, 32'h0000_0004);
    rd(adr(5'h00, FLD_SECOND_GAIN));
    check("gain_reset", rd_q, 32'h0000_0001);
    rd(ADR_IRQ_MASK);
    check("mask_reset", rd_q, 32'h0000_0000);
    rd(10'h3FF);
    check("unmapped", rd_q, 32'h0000_0000);
    wr(adr(5'h1E, FLD_CTRL), 32'h0000_0003);
    rd(adr(5'h1E, FLD_CTRL));
    check("ctrl_mode3", rd_q, 32'h0000_0000);
    run_scan();
    exp_res = 32'hFFFF_FFFF;
    check("result_vec", compare_result_flag, exp_res);
    check("ovf_vec", range_overflow_flag, 32'h0000_0000);
  endtask : t_reset

  task automatic t_greater();
    wr(adr(5'h03, FLD_CTRL), 32'h0000_00D6);
    wr(adr(5'h03, FLD_FIRST_GAIN), 32'h0000_0003);
    wr(adr(5'h03, FLD_SECOND_OPND), 32'h0000_0019);
    wr(adr(5'h03, FLD_SECOND_GAIN), 32'h0000_0007);
    wr(adr(5'h03, FLD_ZERO_OFFSET), 32'hFFFF_FFFB);
    wr(adr(5'h03, FLD_SWITCH_BAND), 32'h0000_0004);
    step(5'h03, 32'h0000_000A, 1'b1);
    rd(adr(5'h03, FLD_ACTUAL));
    check("actual_greater", rd_q, 32'h0000_0019);
    step(5'h03, 32'h0000_0009, 1'b1);
    step(5'h03, 32'h0000_0008, 1'b0);
    step(5'h03, 32'h0000_0009, 1'b0);
  endtask : t_greater

  task automatic t_less();
    wr(adr(5'h05, FLD_CTRL), 32'h0000_0094);
    wr(adr(5'h05, FLD_FIRST_GAIN), 32'hFFFF_FFFE);
    wr(adr(5'h05, FLD_SECOND_OPND), 32'hFFFF_FFF6);
    wr(adr(5'h05, FLD_SWITCH_BAND), 32'h0000_0003);
    step(5'h05, 32'h0000_0002, 1'b0);
    step(5'h05, 32'h0000_0005, 1'b1);
    step(5'h05, 32'h0000_0004, 1'b1);
    rd(adr(5'h05, FLD_ACTUAL));
    check("actual_less", rd_q, 32'hFFFF_FFF8);
    step(5'h05, 32'h0000_0003, 1'b0);
    step(5'h05, 32'h0000_0004, 1'b0);
  endtask : t_less

  task automatic t_same();
    wr(adr(5'h07, FLD_CTRL), 32'h0000_0085);
    wr(adr(5'h07, FLD_SECOND_OPND), 32'h0000_0064);
    wr(adr(5'h07, FLD_SWITCH_BAND), 32'h0000_0002);
    step(5'h07, 32'h0000_0064, 1'b1);
    step(5'h07, 32'h0000_0066, 1'b1);
    step(5'h07, 32'h0000_0067, 1'b0);
    step(5'h07, 32'h0000_0065, 1'b0);
    step(5'h07, 32'h0000_0064, 1'b1);
    step(5'h07, 32'h0000_0061, 1'b0);
  endtask : t_same

  task automatic t_ovf();
    wr(adr(5'h09, FLD_CTRL), 32'h0000_0016);
    wr(adr(5'h09, FLD_FIRST_GAIN), 32'h0000_0002);
    step(5'h09, 32'h4000_0000, 1'b0);
    check("ovf_vec", range_overflow_flag, 32'h0000_0200);
    step(5'h09, 32'h3FFF_FFFF, 1'b1);
    check("ovf_vec", range_overflow_flag, 32'h0000_0000);
    wr(adr(5'h09, FLD_CTRL), 32'h0000_0096);
    wr(adr(5'h09, FLD_SECOND_OPND), 32'h7FFF_FFFF);
    wr(adr(5'h09, FLD_SWITCH_BAND), 32'h0000_0001);
    step(5'h09, 32'h3FFF_FFFF, 1'b0);
    rd(adr(5'h09, FLD_STATE));
    check("state_ovf", rd_q, 32'h0000_0002);
    rd(ADR_OVERFLOW_VEC);
    check("ovf_word", rd_q, 32'h0000_0200);
  endtask : t_ovf

  task automatic t_irq();
    rd(ADR_IRQ_STATUS);
    check("status_all", rd_q, 32'h0000_0007);
    rd(ADR_IRQ_STATUS);
    check("status_cleared", rd_q, 32'h0000_0000);
    wr(ADR_IRQ_MASK, 32'h0000_0001);
    run_scan();
    repeat (2) @(negedge ref_clk);
    check("irq_on", {31'h0, irq}, 32'h0000_0001);
    wr(ADR_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(negedge ref_clk);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    rd(ADR_IRQ_STATUS);
    check("status_done", {31'h0, rd_q[0]}, 32'h0000_0001);
    wr(ADR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    check("irq_off", {31'h0, irq}, 32'h0000_0000);
  endtask : t_irq

  task automatic t_stop();
    wr(adr(5'h14, FLD_CTRL), 32'h0000_000C);
    @(posedge ref_clk);
    run_mode <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check("stop_result", compare_result_flag, exp_res & 32'h0010_0000);
    check("stop_ovf", range_overflow_flag, 32'h0000_0000);
    rd(adr(5'h03, FLD_ACTUAL));
    check("stop_actual", rd_q, 32'h0000_0000);
    @(posedge ref_clk);
    run_mode <= 1'b1;
  endtask : t_stop

  // ---------------------------------------
  // run control
  // ---------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    srst = 1'b1;
    run_mode = 1'b1;
    scan_req = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    compares = 0;
    exp_res = '0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_greater();
    t_less();
    t_same();
    t_ovf();
    t_irq();
    t_stop();
    tally_and_finish();
  end

  // hang guard, well beyond the roughly 900 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : threshold_value_comparator_tb_top

`default_nettype wire

// ==== tvc_comparator.sv ====
// thirty-two threshold comparators evaluated in turn after each program scan
// assumes a synchronous register port and a scan_start pulse from the scan sequencer
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tvc_comparator
  import tvc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // program scan
  input wire logic run_mode,
  input wire logic scan_start,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // contacts
  output logic [NUM_INST-1:0] compare_result_flag,
  output logic [NUM_INST-1:0] range_overflow_flag,
  output logic scan_busy,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic fld_hit(input logic [ADDR_W-1:0] a, input logic [3:0] f);
    fld_hit = (a[ADDR_W-1] == 1'b0) && (a[3:0] == f);
  endfunction : fld_hit

  function automatic logic signed [63:0] sx64(input logic signed [31:0] v);
    sx64 = {{32{v[31]}}, v};
  endfunction : sx64

  function automatic logic fits32(input logic signed [63:0] v);
    fits32 = (v[63:31] == '0) || (v[63:31] == '1);
  endfunction : fits32

  function automatic tvc_mode_t to_mode(input logic [1:0] v);
    case (v)
      2'h1: to_mode = same_value_mode;
      2'h2: to_mode = greater_than_mode;
      default: to_mode = less_than_mode;
    endcase
  endfunction : to_mode

  // ---------------------------------------------------------------------------
  // per-instance storage
  // ---------------------------------------------------------------------------
  tvc_cfg_t cfg_q [NUM_INST];
  logic signed [31:0] opnd1_q [NUM_INST];
  logic signed [31:0] gain1_q [NUM_INST];
  logic signed [31:0] opnd2_q [NUM_INST];
  logic signed [31:0] gain2_q [NUM_INST];
  logic signed [31:0] offs_q [NUM_INST];
  logic signed [31:0] band_q [NUM_INST];
  logic signed [31:0] actual_q [NUM_INST];
  logic [NUM_INST-1:0] res_q;
  logic [NUM_INST-1:0] ovf_q;

  logic [4:0] wr_inst;
  assign wr_inst = reg_addr[8:4];

  // software writes; each instance has its own set
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int k = 0; k < NUM_INST; k++) begin
        cfg_q[k] <= CFG_RESET;
        opnd1_q[k] <= DEF_ZERO;
        gain1_q[k] <= DEF_GAIN;
        opnd2_q[k] <= DEF_ZERO;
        gain2_q[k] <= DEF_GAIN;
        offs_q[k] <= DEF_ZERO;
        band_q[k] <= DEF_ZERO;
      end
    end else if (reg_wr) begin
      if (fld_hit(reg_addr, FLD_CTRL)) begin
        cfg_q[wr_inst].mode <= to_mode(reg_wdata[CTRL_MODE_LSB +: 2]);
        cfg_q[wr_inst].param_access <= reg_wdata[CTRL_ACCESS];
        cfg_q[wr_inst].retentive <= reg_wdata[CTRL_RETAIN];
        cfg_q[wr_inst].gain1_conn <= reg_wdata[CTRL_G1_CONN];
        cfg_q[wr_inst].gain2_conn <= reg_wdata[CTRL_G2_CONN];
        cfg_q[wr_inst].offset_conn <= reg_wdata[CTRL_OFFS_CONN];
        cfg_q[wr_inst].band_conn <= reg_wdata[CTRL_BAND_CONN];
      end
      // full 32-bit signed words
      if (fld_hit(reg_addr, FLD_FIRST_OPND)) begin
        opnd1_q[wr_inst] <= reg_wdata;
      end
      if (fld_hit(reg_addr, FLD_FIRST_GAIN)) begin
        gain1_q[wr_inst] <= reg_wdata;
      end
      if (fld_hit(reg_addr, FLD_SECOND_OPND)) begin
        opnd2_q[wr_inst] <= reg_wdata;
      end
      if (fld_hit(reg_addr, FLD_SECOND_GAIN)) begin
        gain2_q[wr_inst] <= reg_wdata;
      end
      if (fld_hit(reg_addr, FLD_ZERO_OFFSET)) begin
        offs_q[wr_inst] <= reg_wdata;
      end
      if (fld_hit(reg_addr, FLD_SWITCH_BAND)) begin
        band_q[wr_inst] <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // scan sequencer: one instance per clock after scan_start
  // ---------------------------------------------------------------------------
  logic busy_q;
  logic [4:0] idx_q;
  logic eval_en;
  assign eval_en = busy_q && run_mode;

  always_ff @(posedge ref_clk) begin
    if (srst || !run_mode) begin
      busy_q <= 1'b0;
      idx_q <= '0;
    end else if (!busy_q && scan_start) begin
      busy_q <= 1'b1;
      idx_q <= '0;
    end else if (busy_q) begin
      idx_q <= idx_q + 5'h1;
      if (idx_q == LAST_INST) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // datapath for the selected instance
  // ---------------------------------------------------------------------------
  tvc_cfg_t cur_cfg;
  logic signed [31:0] g1_eff, g2_eff, offs_eff, band_eff;
  logic signed [63:0] actual_w, setp_w, hi_w, lo_w;
  logic ovf_now, res_old, res_new;

  always_comb begin
    cur_cfg = cfg_q[idx_q];
    g1_eff = cur_cfg.gain1_conn ? gain1_q[idx_q] : DEF_GAIN;
    g2_eff = cur_cfg.gain2_conn ? gain2_q[idx_q] : DEF_GAIN;
    offs_eff = cur_cfg.offset_conn ? offs_q[idx_q] : DEF_ZERO;
    band_eff = cur_cfg.band_conn ? band_q[idx_q] : DEF_ZERO;
    actual_w = sx64(opnd1_q[idx_q]) * sx64(g1_eff) + sx64(offs_eff);
    setp_w = sx64(opnd2_q[idx_q]) * sx64(g2_eff);
    hi_w = setp_w + sx64(band_eff);
    lo_w = setp_w - sx64(band_eff);
    ovf_now = !fits32(actual_w) || !fits32(hi_w) || !fits32(lo_w);
    res_old = res_q[idx_q];
    case (cur_cfg.mode)
      greater_than_mode: res_new = res_old ? (actual_w >= lo_w) : (actual_w >= setp_w);
      same_value_mode: res_new = res_old ? (actual_w >= lo_w && actual_w <= hi_w)
                                         : (actual_w == setp_w);
      less_than_mode: res_new = res_old ? (actual_w <= hi_w) : (actual_w <= setp_w);
      default: res_new = 1'b0;
    endcase
    if (ovf_now) begin
      res_new = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // flags and actual values
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      res_q <= '0;
      ovf_q <= '0;
      for (int k = 0; k < NUM_INST; k++) begin
        actual_q[k] <= DEF_ZERO;
      end
    end else if (!run_mode) begin
      for (int k = 0; k < NUM_INST; k++) begin
        if (!cfg_q[k].retentive) begin
          res_q[k] <= 1'b0;
          ovf_q[k] <= 1'b0;
          actual_q[k] <= DEF_ZERO;
        end
      end
    end else if (eval_en) begin
      res_q[idx_q] <= res_new;
      ovf_q[idx_q] <= ovf_now;
      actual_q[idx_q] <= actual_w[31:0];
    end
  end

  assign compare_result_flag = res_q;
  assign range_overflow_flag = ovf_q;
  assign scan_busy = busy_q;

  // ---------------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------------
  logic [EV_W-1:0] ev_set, irq_stat_q, irq_mask_q;
  logic irq_q;

  always_comb begin
    ev_set = '0;
    ev_set[EV_SCAN_DONE] = eval_en && (idx_q == LAST_INST);
    ev_set[EV_OVERFLOW] = eval_en && ovf_now && !ovf_q[idx_q];
    ev_set[EV_RESULT_CHG] = eval_en && (res_new != res_q[idx_q]);
  end

  // set wins over the clear of a status read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else if (reg_rd && reg_addr == ADR_IRQ_STATUS) begin
      irq_stat_q <= ev_set;
    end else begin
      irq_stat_q <= irq_stat_q | ev_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_mask_q <= MASK_RESET;
    end else if (reg_wr && reg_addr == ADR_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // ---------------------------------------------------------------------------
  // read port: data in the cycle after the strobe only
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_mux;
  logic [4:0] rd_inst;

  always_comb begin
    rd_inst = reg_addr[8:4];
    rd_mux = '0;
    if (fld_hit(reg_addr, FLD_CTRL)) begin
      rd_mux[7:0] = cfg_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_FIRST_OPND)) begin
      rd_mux = opnd1_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_FIRST_GAIN)) begin
      rd_mux = gain1_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_SECOND_OPND)) begin
      rd_mux = opnd2_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_SECOND_GAIN)) begin
      rd_mux = gain2_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_ZERO_OFFSET)) begin
      rd_mux = offs_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_SWITCH_BAND)) begin
      rd_mux = band_q[rd_inst];
    end else if (fld_hit(reg_addr, FLD_STATE)) begin
      rd_mux[1:0] = {ovf_q[rd_inst], res_q[rd_inst]};
    end else if (fld_hit(reg_addr, FLD_ACTUAL)) begin
      rd_mux = actual_q[rd_inst];
    end else if (reg_addr == ADR_IRQ_STATUS) begin
      rd_mux[EV_W-1:0] = irq_stat_q;
    end else if (reg_addr == ADR_IRQ_MASK) begin
      rd_mux[EV_W-1:0] = irq_mask_q;
    end else if (reg_addr == ADR_RESULT_VEC) begin
      rd_mux = res_q;
    end else if (reg_addr == ADR_OVERFLOW_VEC) begin
      rd_mux = ovf_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [4:0] last_idx_q;
  always_ff @(posedge ref_clk) begin
    last_idx_q <= idx_q;
  end

  property p_ovf_blocks_result;
    @(posedge ref_clk) disable iff (srst) (res_q & ovf_q) == '0;
  endproperty
  a_ovf_blocks_result: assert property (p_ovf_blocks_result) else $error("result high with overflow");

  property p_reset_mode_less;
    @(posedge ref_clk) srst |=> cfg_q[0].mode == less_than_mode && cfg_q[31].mode == less_than_mode;
  endproperty
  a_reset_mode_less: assert property (p_reset_mode_less) else $error("mode not less-than after reset");

  property p_reset_access;
    @(posedge ref_clk) srst |=> cfg_q[0].param_access && cfg_q[31].param_access;
  endproperty
  a_reset_access: assert property (p_reset_access) else $error("access bit not permitted");

  property p_scan_len;
    @(posedge ref_clk) disable iff (srst || !run_mode)
      (!busy_q && scan_start) |=> busy_q && idx_q == 5'h00 ##31 busy_q && idx_q == LAST_INST ##1 !busy_q;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan did not take 32 cycles");

  property p_ovf_follows;
    @(posedge ref_clk) disable iff (srst || !run_mode) eval_en |=> ovf_q[last_idx_q] == $past(ovf_now);
  endproperty
  a_ovf_follows: assert property (p_ovf_follows) else $error("overflow flag mismatch");

  property p_greater_set;
    @(posedge ref_clk) disable iff (srst || !run_mode)
      (eval_en && cur_cfg.mode == greater_than_mode && !ovf_now && actual_w >= setp_w)
      |=> res_q[last_idx_q];
  endproperty
  a_greater_set: assert property (p_greater_set) else $error("greater mode did not set");

  property p_less_clear;
    @(posedge ref_clk) disable iff (srst || !run_mode)
      (eval_en && cur_cfg.mode == less_than_mode && actual_w > hi_w) |=> !res_q[last_idx_q];
  endproperty
  a_less_clear: assert property (p_less_clear) else $error("less mode did not clear");

  property p_same_set;
    @(posedge ref_clk) disable iff (srst || !run_mode)
      (eval_en && cur_cfg.mode == same_value_mode && !ovf_now && actual_w == setp_w)
      |=> res_q[last_idx_q];
  endproperty
  a_same_set: assert property (p_same_set) else $error("equal mode did not set");

  property p_stop_clears;
    @(posedge ref_clk) disable iff (srst)
      (!run_mode && !cfg_q[0].retentive) |=> !res_q[0] && !ovf_q[0] && actual_q[0] == DEF_ZERO;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear");

  property p_default_gain;
    @(posedge ref_clk) disable iff (srst) !cur_cfg.gain1_conn |-> g1_eff == DEF_GAIN;
  endproperty
  a_default_gain: assert property (p_default_gain) else $error("default gain not one");

  c_scan_done: cover property (@(posedge ref_clk) disable iff (srst) ev_set[EV_SCAN_DONE]);
  c_overflow: cover property (@(posedge ref_clk) disable iff (srst) ev_set[EV_OVERFLOW]);
  c_result_chg: cover property (@(posedge ref_clk) disable iff (srst) ev_set[EV_RESULT_CHG]);
  c_irq: cover property (@(posedge ref_clk) disable iff (srst) irq_q);

endmodule : tvc_comparator

`default_nettype wire

// ==== tvc_pkg.sv ====
// constants, types and field layout of the threshold value comparator
// assumes one clock domain and a plain word-addressed register port
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package tvc_pkg;

  localparam int unsigned NUM_INST = 32;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // per-instance word fields, address = {0, instance, field}
  localparam logic [3:0] FLD_CTRL = 4'h0;
  localparam logic [3:0] FLD_FIRST_OPND = 4'h1;
  localparam logic [3:0] FLD_FIRST_GAIN = 4'h2;
  localparam logic [3:0] FLD_SECOND_OPND = 4'h3;
  localparam logic [3:0] FLD_SECOND_GAIN = 4'h4;
  localparam logic [3:0] FLD_ZERO_OFFSET = 4'h5;
  localparam logic [3:0] FLD_SWITCH_BAND = 4'h6;
  localparam logic [3:0] FLD_STATE = 4'h7;
  localparam logic [3:0] FLD_ACTUAL = 4'h8;

  // global words, address = {1, 0, index}
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 10'h200;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 10'h201;
  localparam logic [ADDR_W-1:0] ADR_RESULT_VEC = 10'h202;
  localparam logic [ADDR_W-1:0] ADR_OVERFLOW_VEC = 10'h203;

  // control word bit positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACCESS = 2;
  localparam int unsigned CTRL_RETAIN = 3;
  localparam int unsigned CTRL_G1_CONN = 4;
  localparam int unsigned CTRL_G2_CONN = 5;
  localparam int unsigned CTRL_OFFS_CONN = 6;
  localparam int unsigned CTRL_BAND_CONN = 7;

  // interrupt event bits
  localparam int unsigned EV_SCAN_DONE = 0;
  localparam int unsigned EV_OVERFLOW = 1;
  localparam int unsigned EV_RESULT_CHG = 2;
  localparam int unsigned EV_W = 3;

  localparam logic signed [31:0] DEF_GAIN = 32'sh0000_0001;
  localparam logic signed [31:0] DEF_ZERO = 32'sh0000_0000;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam logic [4:0] LAST_INST = 5'h1F;

  typedef enum logic [1:0] {
    less_than_mode,
    same_value_mode,
    greater_than_mode
  } tvc_mode_t;

  typedef struct packed {
    logic band_conn;
    logic offset_conn;
    logic gain2_conn;
    logic gain1_conn;
    logic retentive;
    logic param_access;
    tvc_mode_t mode;
  } tvc_cfg_t;

  localparam tvc_cfg_t CFG_RESET = '{band_conn: 1'b0, offset_conn: 1'b0, gain2_conn: 1'b0,
                                     gain1_conn: 1'b0, retentive: 1'b0, param_access: 1'b1,
                                     mode: less_than_mode};

endpackage : tvc_pkg

// ==== tvc_scan_model.sv ====
// scan sequencer model: one scan_start pulse per request, then reports the scan's end
// assumes the comparator's scan_busy output and a one-cycle scan_req pulse from the bench
`timescale 1ns/1ps
`default_nettype none

module tvc_scan_model
  import tvc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bench side
  input wire logic scan_req,
  output logic scan_done,
  // comparator side
  input wire logic scan_busy,
  output logic scan_start
);
  logic pend_q;
  logic seen_q;

  // ---------------------------------------
  // scan sequencing
  // ---------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_q <= 1'b0;
      seen_q <= 1'b0;
      scan_start <= 1'b0;
      scan_done <= 1'b0;
    end else begin
      if (scan_req) begin
        pend_q <= 1'b1;
      end else if (scan_start) begin
        pend_q <= 1'b0;
      end
      // one pulse after the logic pass, never while a scan is running
      scan_start <= pend_q && !scan_busy && !scan_start && !seen_q;
      if (scan_start) begin
        seen_q <= 1'b1;
      end else if (seen_q && !scan_busy) begin
        seen_q <= 1'b0;
      end
      scan_done <= seen_q && !scan_busy;
    end
  end
endmodule : tvc_scan_model

`default_nettype wire
